// ==== core/clockgen_map.svh ====
`ifndef CLOCKGEN_MAP_SVH
`define CLOCKGEN_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CONFIG 12'h000
`define OFS_IRQ_CONTROL 12'h004
`define OFS_FLAGS 12'h008
`define OFS_WATCHDOG_ARM 12'h00C
`define OFS_WATCHDOG_RATE 12'h010
`define OFS_TICK_RATE 12'h014
`define OFS_STATUS 12'h018

// ****************************************************************
// field positions
// ****************************************************************
`define CFG_CME_BIT 0
`define CFG_SELF_CLOCK_MODE_ENABLE_BIT 1
`define CFG_PSEUDO_STOP_SELECT_BIT 2
`define IRQ_TICK_BIT 0
`define IRQ_LOCK_BIT 1
`define IRQ_SELF_BIT 2

// ****************************************************************
// reset values and codes
// ****************************************************************
`define CFG_RESET 3'h3
`define IRQ_CTRL_RESET 3'h0
`define ARM_FIRST 8'h55
`define ARM_SECOND 8'hAA

// ****************************************************************
// timing counts
// ****************************************************************
`define RESET_DRIVE_CYCLES 8'h80
`define SYNC_EXTRA_CYCLES 8'h03
`define RESET_WAIT_CYCLES 8'h40
`define CHECK_WINDOWS 6'h32
`define CHECK_WINDOW_CYCLES 16'h1000

`endif

// ==== core/clockgen_pkg.sv ====
package clockgen_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_CHECK,
    SEQ_DRIVE,
    SEQ_WAIT,
    SEQ_DONE
  } seq_state_e;

  // reset source pending bits
  typedef struct packed {
    logic clock_monitor;
    logic watchdog;
    logic power;
  } reset_cause_s;

  // vector choice reported after the sequence
  typedef enum logic [1:0] {
    VEC_POWER_ON,
    VEC_EXTERNAL,
    VEC_CLOCK_MONITOR,
    VEC_WATCHDOG
  } vector_e;

endpackage : clockgen_pkg

// ==== core/clock_reset_interrupt_gen.sv ====
// What this block does
// - clock monitor reset needs monitor on, clock lost, self-clock off
// - clock monitor reset forces both monitor and self-clock enables to 1
// - after clock monitor reset enter self-clock, start sequence at the drive step, no check
// - a passing check leaves self-clock mode even mid-sequence
// - a correct arm pair restarts the watchdog period
// - period expiring without a correct arm pair causes watchdog reset
// - power or low-voltage reset first checks clock, then starts sequence
// - after 50 failed check windows the sequence runs in self-clock mode
// - tick request each period, masked by its enable
// - tick flag sets on timeout, clears only by writing one
// - with pseudo-stop select set, tick counter runs in pseudo stop
// - lock request on any lock change, masked by its enable
// - lock change flag sets on change, clears only by writing one
// - self-clock request on entry and exit, masked by its enable
// - self-clock entered on failed check after reset, full stop, monitor loss
// - self-clock change flag sets on change, clears by writing one
// - monitor and self-clock enabled: clock loss enters self-clock, no reset
// - any reset drives reset line low 128+n cycles, then waits 64; power reset also drives it low through the clock check
// - sample line: low gives external, else monitor, watchdog, power vector
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "clockgen_map.svh"

module clock_reset_interrupt_gen #(
  parameter int WATCHDOG_BASE = 4096,
  parameter int TICK_BASE = 1024,
  parameter logic [15:0] CHECK_WINDOW_LEN = `CHECK_WINDOW_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_reset_req,
  input wire logic clock_loss,
  input wire logic clock_good,
  input wire logic pll_locked,
  input wire logic pseudo_stop,
  input wire logic full_stop_exit,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_n,
  output logic internal_reset,
  output logic self_clock_mode,
  output logic [1:0] vector_sel,
  output logic tick_irq,
  output logic pll_lock_irq,
  output logic self_clock_irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [2:0] config_r;
  logic [2:0] irq_ctrl_r;
  logic [2:0] flags_r;
  logic [2:0] watchdog_rate_r;
  logic [2:0] tick_rate_r;
  logic arm_first_seen_r;
  logic [31:0] watchdog_cnt_r;
  logic [31:0] tick_cnt_r;
  logic watchdog_expire;
  logic tick_expire;
  logic lock_prev_r;
  logic self_prev_r;
  logic self_clock_r;
  logic monitor_reset;
  clockgen_pkg::reset_cause_s cause_r;
  clockgen_pkg::seq_state_e state_r;
  logic [7:0] seq_cnt_r;
  logic [15:0] window_cnt_r;
  logic [5:0] window_num_r;
  logic wr;
  logic rd;
  logic [31:0] rd_nxt;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;

  // clock loss with self-clock off is a reset, with it on self-clock mode
  assign monitor_reset = config_r[`CFG_CME_BIT] && clock_loss && !config_r[`CFG_SELF_CLOCK_MODE_ENABLE_BIT];

  // ****************************************************************
  // register bus
  // ****************************************************************

  // configuration; monitor reset returns defaults with both enables set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      config_r <= `CFG_RESET;
      irq_ctrl_r <= `IRQ_CTRL_RESET;
      watchdog_rate_r <= 3'h0;
      tick_rate_r <= 3'h0;
    end else if (monitor_reset || power_reset_req) begin
      config_r <= `CFG_RESET;
      irq_ctrl_r <= `IRQ_CTRL_RESET;
      watchdog_rate_r <= 3'h0;
      tick_rate_r <= 3'h0;
    end else if (wr && pready) begin
      if (paddr == `OFS_CONFIG) begin
        config_r <= pwdata[2:0];
      end
      if (paddr == `OFS_IRQ_CONTROL) begin
        irq_ctrl_r <= pwdata[2:0];
      end
      if (paddr == `OFS_WATCHDOG_RATE) begin
        watchdog_rate_r <= pwdata[2:0];
      end
      if (paddr == `OFS_TICK_RATE) begin
        tick_rate_r <= pwdata[2:0];
      end
    end
  end

  // read mux
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (paddr)
      `OFS_CONFIG: rd_nxt = {29'h0, config_r};
      `OFS_IRQ_CONTROL: rd_nxt = {29'h0, irq_ctrl_r};
      `OFS_FLAGS: rd_nxt = {29'h0, flags_r};
      `OFS_WATCHDOG_RATE: rd_nxt = {29'h0, watchdog_rate_r};
      `OFS_TICK_RATE: rd_nxt = {29'h0, tick_rate_r};
      `OFS_STATUS: rd_nxt = {26'h0, vector_sel, pll_locked, self_clock_r, internal_reset, reset_pin_out};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // one wait state: ready in the second access cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && (paddr > `OFS_STATUS || paddr[1:0] != 2'h0);
      prdata <= (rd && !pready) ? rd_nxt : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // watchdog
  // ****************************************************************

  // arming pair tracker and timeout counter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arm_first_seen_r <= 1'b0;
      watchdog_cnt_r <= 32'h0000_0000;
    end else if (watchdog_rate_r == 3'h0 || state_r != clockgen_pkg::SEQ_IDLE) begin
      arm_first_seen_r <= 1'b0;
      watchdog_cnt_r <= 32'h0000_0000;
    end else if (wr && pready && paddr == `OFS_WATCHDOG_ARM) begin
      if (arm_first_seen_r && pwdata[7:0] == `ARM_SECOND) begin
        arm_first_seen_r <= 1'b0;
        watchdog_cnt_r <= 32'h0000_0000;
      end else begin
        arm_first_seen_r <= (pwdata[7:0] == `ARM_FIRST);
        watchdog_cnt_r <= watchdog_cnt_r + 32'h1;
      end
    end else begin
      watchdog_cnt_r <= watchdog_cnt_r + 32'h1;
    end
  end

  assign watchdog_expire = (watchdog_rate_r != 3'h0) &&
    (watchdog_cnt_r >= (32'(WATCHDOG_BASE) << watchdog_rate_r) - 32'h1);

  // ****************************************************************
  // periodic tick
  // ****************************************************************

  // counter stops in full stop, runs in pseudo stop when selected
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_r <= 32'h0000_0000;
    end else if (tick_rate_r == 3'h0 || (pseudo_stop && !config_r[`CFG_PSEUDO_STOP_SELECT_BIT])) begin
      tick_cnt_r <= 32'h0000_0000;
    end else if (tick_expire) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  assign tick_expire = (tick_rate_r != 3'h0) && (tick_cnt_r >= (32'(TICK_BASE) << tick_rate_r) - 32'h1);

  // ****************************************************************
  // self-clock mode
  // ****************************************************************

  // enter on monitor loss or failed check, leave when the check passes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      self_clock_r <= 1'b0;
    end else if (clock_loss && config_r[`CFG_CME_BIT]) begin
      self_clock_r <= 1'b1;
    end else if (full_stop_exit && !config_r[`CFG_PSEUDO_STOP_SELECT_BIT] && !clock_good) begin
      self_clock_r <= 1'b1;
    end else if (state_r == clockgen_pkg::SEQ_CHECK && window_num_r == `CHECK_WINDOWS) begin
      self_clock_r <= 1'b1;
    end else if (clock_good) begin
      self_clock_r <= 1'b0;
    end
  end

  // ****************************************************************
  // interrupt flags
  // ****************************************************************

  // edges of lock and self-clock state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_prev_r <= 1'b0;
      self_prev_r <= 1'b0;
    end else begin
      lock_prev_r <= pll_locked;
      self_prev_r <= self_clock_r;
    end
  end

  // sticky flags, set beats the write-one clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_r <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr && pready && paddr == `OFS_FLAGS && pwdata[i]) begin
          flags_r[i] <= 1'b0;
        end
      end
      if (tick_expire) begin
        flags_r[`IRQ_TICK_BIT] <= 1'b1;
      end
      if (pll_locked != lock_prev_r) begin
        flags_r[`IRQ_LOCK_BIT] <= 1'b1;
      end
      if (self_clock_r != self_prev_r) begin
        flags_r[`IRQ_SELF_BIT] <= 1'b1;
      end
    end
  end

  // requests are flag and enable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_irq <= 1'b0;
      pll_lock_irq <= 1'b0;
      self_clock_irq <= 1'b0;
    end else begin
      tick_irq <= flags_r[`IRQ_TICK_BIT] && irq_ctrl_r[`IRQ_TICK_BIT];
      pll_lock_irq <= flags_r[`IRQ_LOCK_BIT] && irq_ctrl_r[`IRQ_LOCK_BIT];
      self_clock_irq <= flags_r[`IRQ_SELF_BIT] && irq_ctrl_r[`IRQ_SELF_BIT];
    end
  end

  // ****************************************************************
  // reset sequencer
  // ****************************************************************

  // pending causes, kept until the vector is chosen
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cause_r <= '0;
    end else if (state_r == clockgen_pkg::SEQ_DONE) begin
      cause_r <= '0;
    end else begin
      if (monitor_reset) begin
        cause_r.clock_monitor <= 1'b1;
      end
      if (watchdog_expire) begin
        cause_r.watchdog <= 1'b1;
      end
      if (power_reset_req) begin
        cause_r.power <= 1'b1;
      end
    end
  end

  // check windows, drive, wait, sample
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= clockgen_pkg::SEQ_CHECK;
      seq_cnt_r <= 8'h00;
      window_cnt_r <= 16'h0000;
      window_num_r <= 6'h00;
    end else if (power_reset_req) begin
      state_r <= clockgen_pkg::SEQ_CHECK;
      seq_cnt_r <= 8'h00;
      window_cnt_r <= 16'h0000;
      window_num_r <= 6'h00;
    end else if (monitor_reset || watchdog_expire || !reset_pin_in && state_r == clockgen_pkg::SEQ_IDLE) begin
      state_r <= clockgen_pkg::SEQ_DRIVE;
      seq_cnt_r <= 8'h00;
    end else begin
      unique case (state_r)
        clockgen_pkg::SEQ_IDLE: begin
          seq_cnt_r <= 8'h00;
        end
        clockgen_pkg::SEQ_CHECK: begin
          if (clock_good || window_num_r == `CHECK_WINDOWS) begin
            state_r <= clockgen_pkg::SEQ_DRIVE;
          end else if (window_cnt_r == CHECK_WINDOW_LEN - 16'h1) begin
            window_cnt_r <= 16'h0000;
            window_num_r <= window_num_r + 6'h1;
          end else begin
            window_cnt_r <= window_cnt_r + 16'h1;
          end
        end
        clockgen_pkg::SEQ_DRIVE: begin
          if (seq_cnt_r == `RESET_DRIVE_CYCLES + `SYNC_EXTRA_CYCLES - 8'h1) begin
            state_r <= clockgen_pkg::SEQ_WAIT;
            seq_cnt_r <= 8'h00;
          end else begin
            seq_cnt_r <= seq_cnt_r + 8'h1;
          end
        end
        clockgen_pkg::SEQ_WAIT: begin
          if (seq_cnt_r == `RESET_WAIT_CYCLES - 8'h1) begin
            state_r <= clockgen_pkg::SEQ_DONE;
          end else begin
            seq_cnt_r <= seq_cnt_r + 8'h1;
          end
        end
        clockgen_pkg::SEQ_DONE: begin
          if (reset_pin_in) begin
            state_r <= clockgen_pkg::SEQ_IDLE; // held while pin is low externally
          end
        end
        default: state_r <= clockgen_pkg::SEQ_IDLE;
      endcase
    end
  end

  // pin drive, internal reset and vector choice
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= 1'b0;
      internal_reset <= 1'b1;
      vector_sel <= clockgen_pkg::VEC_POWER_ON;
      self_clock_mode <= 1'b0;
    end else begin
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= !(state_r == clockgen_pkg::SEQ_DRIVE || state_r == clockgen_pkg::SEQ_CHECK);
      internal_reset <= state_r != clockgen_pkg::SEQ_IDLE;
      self_clock_mode <= self_clock_r;
      if (state_r == clockgen_pkg::SEQ_WAIT && seq_cnt_r == `RESET_WAIT_CYCLES - 8'h1) begin
        if (!reset_pin_in) begin
          vector_sel <= clockgen_pkg::VEC_EXTERNAL;
        end else if (cause_r.clock_monitor) begin
          vector_sel <= clockgen_pkg::VEC_CLOCK_MONITOR;
        end else if (cause_r.watchdog) begin
          vector_sel <= clockgen_pkg::VEC_WATCHDOG;
        end else begin
          vector_sel <= clockgen_pkg::VEC_POWER_ON;
        end
      end
    end
  end

endmodule : clock_reset_interrupt_gen

// ==== dv/clockgen_monitor.sv ====
`timescale 1ns/1ns
// ****************************************************************
// port checks for the reset and interrupt generator
// ****************************************************************
module clockgen_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic clock_loss,
  input wire logic clock_good,
  input wire logic full_stop_exit,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n,
  input wire logic internal_reset,
  input wire logic self_clock_mode,
  input wire logic tick_irq,
  input wire logic pll_lock_irq
);
  logic [7:0] low_cnt_r;
  logic [7:0] hi_cnt_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // saturating run lengths of pin drive and pin release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt_r <= 8'h00;
      hi_cnt_r <= 8'h00;
    end else begin
      low_cnt_r <= reset_pin_oe_n ? 8'h00 : low_cnt_r + {7'h00, low_cnt_r != 8'hFF};
      hi_cnt_r <= !reset_pin_oe_n ? 8'h00 : hi_cnt_r + {7'h00, hi_cnt_r != 8'hFF};
    end
  end

  pin_value_zero_a: assert property (reset_pin_out == 1'b0)
    else $error("reset pin drive value not zero");
  drive_length_a: assert property ($rose(reset_pin_oe_n) |-> low_cnt_r >= 8'h83)
    else $error("reset pin released too early");
  drive_holds_rst_a: assert property (!reset_pin_oe_n |-> internal_reset)
    else $error("pin driven without internal reset");
  release_wait_a: assert property (reset_pin_oe_n && hi_cnt_r < 8'h40 |-> internal_reset)
    else $error("internal reset ended inside wait");
  reset_end_a: assert property ($fell(internal_reset) |-> hi_cnt_r >= 8'h40 && $past(reset_pin_in))
    else $error("reset ended without high pin sample");
  self_clock_exit_a: assert property (
    self_clock_mode && clock_good && !clock_loss && !full_stop_exit |-> ##[1:24] !self_clock_mode)
    else $error("self clock kept with good clock");
  ready_timing_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero when idle");

  // main scenarios reached
  cover property ($rose(tick_irq));
  cover property ($rose(pll_lock_irq));
  cover property ($rose(self_clock_mode));
endmodule : clockgen_monitor

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
`include "clockgen_map.svh"
// ****************************************************************
// bench
// ****************************************************************
module tb_top;
  logic clk, resetn, psel, penable, pwrite, power_reset_req, clock_loss, clock_good;
  logic pll_locked, pseudo_stop, full_stop_exit, reset_pin_in, reset_pin_out, reset_pin_oe_n;
  logic internal_reset, self_clock_mode, tick_irq, pll_lock_irq, self_clock_irq, pready, pslverr, re;
  logic ext_low;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [1:0] vector_sel;
  int n_errors, cmp_count, n;

  // pin level with pull-up
  assign reset_pin_in = !reset_pin_oe_n ? reset_pin_out : !ext_low;

  clock_reset_interrupt_gen #(.WATCHDOG_BASE(16), .TICK_BASE(8), .CHECK_WINDOW_LEN(16'h0008)) dut (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_reset_req(power_reset_req),
    .clock_loss(clock_loss), .clock_good(clock_good), .pll_locked(pll_locked), .pseudo_stop(pseudo_stop),
    .full_stop_exit(full_stop_exit), .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
    .reset_pin_oe_n(reset_pin_oe_n), .internal_reset(internal_reset), .self_clock_mode(self_clock_mode),
    .vector_sel(vector_sel), .tick_irq(tick_irq), .pll_lock_irq(pll_lock_irq), .self_clock_irq(self_clock_irq));

  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // one apb transfer, released after the ready edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task cmp(input logic [31:0] g, input logic [31:0] x, input string m);
    cmp_count++;
    if (g !== x) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask : cmp

  task wt(input int c);
    repeat (c) @(posedge clk);
  endtask : wt

  task settle;
    for (int i = 0; i < 2000 && internal_reset !== 1'b0; i++) @(posedge clk);
  endtask : settle

  task t_boot;
    n = 0;
    while (reset_pin_oe_n !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    cmp(n >= 531 && n <= 540, 1, "boot drive length");
    cmp(self_clock_mode, 1, "self clock in boot");
    settle;
    cmp(vector_sel, 0, "power vector");
    apb(0, `OFS_STATUS, 0);
    cmp(rq, 32'h0000_0004, "status after boot");
    apb(0, `OFS_CONFIG, 0);
    cmp(rq, 3, "config reset value");
    apb(0, 12'h01C, 0);
    cmp({re, rq[30:0]}, 32'h80000000, "unmapped read");
    apb(0, `OFS_FLAGS, 0);
    cmp(rq[2], 1, "self clock flag set");
    apb(1, `OFS_FLAGS, 0);
    apb(0, `OFS_FLAGS, 0);
    cmp(rq[2], 1, "flag kept on zero write");
    apb(1, `OFS_FLAGS, 4);
    apb(0, `OFS_FLAGS, 0);
    cmp(rq[2], 0, "flag cleared");
    apb(1, `OFS_IRQ_CONTROL, 4);
    clock_good <= 1'b1;
    wt(20);
    cmp(self_clock_mode, 0, "self clock exit");
    cmp(self_clock_irq, 1, "self clock irq on exit");
    apb(1, `OFS_FLAGS, 4);
    wt(2);
    cmp(self_clock_irq, 0, "irq follows flag");
    apb(1, `OFS_IRQ_CONTROL, 0);
    $display("boot test done");
  endtask : t_boot

  task t_tick;
    apb(1, `OFS_TICK_RATE, 1);
    apb(1, `OFS_IRQ_CONTROL, 1);
    for (int i = 0; i < 40 && tick_irq !== 1'b1; i++) @(posedge clk);
    cmp(tick_irq, 1, "tick irq");
    apb(1, `OFS_IRQ_CONTROL, 0);
    apb(1, `OFS_FLAGS, 1);
    wt(20);
    apb(0, `OFS_FLAGS, 0);
    cmp(rq[0], 1, "tick flag set");
    cmp(tick_irq, 0, "tick irq masked");
    apb(1, `OFS_CONFIG, 7);
    pseudo_stop <= 1'b1;
    apb(1, `OFS_FLAGS, 1);
    wt(20);
    apb(0, `OFS_FLAGS, 0);
    cmp(rq[0], 1, "tick runs in pseudo stop");
    apb(1, `OFS_CONFIG, 3);
    apb(1, `OFS_FLAGS, 1);
    wt(40);
    apb(0, `OFS_FLAGS, 0);
    cmp(rq[0], 0, "tick halted in stop");
    pseudo_stop <= 1'b0;
    apb(1, `OFS_TICK_RATE, 0);
    apb(1, `OFS_FLAGS, 1);
    $display("tick test done");
  endtask : t_tick

  task t_lock;
    apb(1, `OFS_IRQ_CONTROL, 2);
    pll_locked <= 1'b1;
    wt(4);
    cmp(pll_lock_irq, 1, "lock gained irq");
    apb(0, `OFS_FLAGS, 0);
    cmp(rq[1], 1, "lock flag set");
    apb(1, `OFS_FLAGS, 2);
    wt(2);
    cmp(pll_lock_irq, 0, "lock flag cleared");
    pll_locked <= 1'b0;
    wt(4);
    cmp(pll_lock_irq, 1, "lock lost irq");
    apb(1, `OFS_FLAGS, 2);
    apb(1, `OFS_IRQ_CONTROL, 0);
    $display("lock test done");
  endtask : t_lock

  task t_watchdog;
    apb(1, `OFS_WATCHDOG_RATE, 1);
    repeat (8) begin
      apb(1, `OFS_WATCHDOG_ARM, `ARM_FIRST);
      apb(1, `OFS_WATCHDOG_ARM, `ARM_SECOND);
      wt(10);
    end
    cmp(internal_reset, 0, "armed watchdog quiet");
    apb(1, `OFS_WATCHDOG_ARM, `ARM_SECOND);
    apb(1, `OFS_WATCHDOG_ARM, `ARM_FIRST);
    for (int i = 0; i < 80 && internal_reset !== 1'b1; i++) @(posedge clk);
    cmp(internal_reset, 1, "watchdog reset");
    settle;
    cmp(vector_sel, 3, "watchdog vector");
    apb(1, `OFS_WATCHDOG_RATE, 0);
    $display("watchdog test done");
  endtask : t_watchdog

  task t_monitor;
    clock_good <= 1'b0;
    clock_loss <= 1'b1;
    wt(4);
    cmp(self_clock_mode, 1, "loss enters self clock");
    cmp(internal_reset, 0, "loss without reset");
    clock_loss <= 1'b0;
    clock_good <= 1'b1;
    wt(20);
    clock_good <= 1'b0;
    full_stop_exit <= 1'b1;
    wt(1);
    full_stop_exit <= 1'b0;
    wt(4);
    cmp(self_clock_mode, 1, "full stop check fail");
    clock_good <= 1'b1;
    wt(20);
    apb(1, `OFS_CONFIG, 0);
    clock_loss <= 1'b1;
    wt(4);
    cmp(internal_reset, 0, "monitor off no reset");
    clock_loss <= 1'b0;
    apb(1, `OFS_CONFIG, 1);
    clock_good <= 1'b0;
    clock_loss <= 1'b1;
    wt(4);
    cmp(internal_reset, 1, "monitor reset");
    cmp(self_clock_mode, 1, "monitor reset self clock");
    clock_loss <= 1'b0;
    apb(0, `OFS_CONFIG, 0);
    cmp(rq, 3, "config forced");
    clock_good <= 1'b1;
    wt(20);
    cmp({self_clock_mode, internal_reset}, 1, "exit mid sequence");
    settle;
    cmp(vector_sel, 2, "monitor vector");
    $display("monitor test done");
  endtask : t_monitor

  task t_external;
    ext_low <= 1'b1;
    power_reset_req <= 1'b1;
    wt(1);
    power_reset_req <= 1'b0;
    wt(300);
    cmp(internal_reset, 1, "held by low pin");
    ext_low <= 1'b0;
    settle;
    cmp(vector_sel, 1, "external vector");
    $display("external test done");
  endtask : t_external

  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // main sequence
  initial begin
    {resetn, psel, penable, pwrite, power_reset_req, clock_loss, clock_good} = 7'h00;
    {pll_locked, pseudo_stop, full_stop_exit, ext_low} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    wt(2);
    resetn <= 1'b1;
    t_boot;
    t_tick;
    t_lock;
    t_watchdog;
    t_monitor;
    t_external;
    print_verdict;
  end

  // hang guard
  initial begin
    #2000000;
    n_errors++;
    print_verdict;
  end
endmodule : tb_top

bind clock_reset_interrupt_gen clockgen_monitor mon (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_loss(clock_loss), .clock_good(clock_good),
  .full_stop_exit(full_stop_exit), .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
  .reset_pin_oe_n(reset_pin_oe_n), .internal_reset(internal_reset), .self_clock_mode(self_clock_mode),
  .tick_irq(tick_irq), .pll_lock_irq(pll_lock_irq));
